// file: logic/flm_pkg.sv
package flm_pkg;

  // access width codes as seen on the port configuration
  localparam logic [1:0] FLM_WIDTH_8 = 2'h0;
  localparam logic [1:0] FLM_WIDTH_16 = 2'h1;
  localparam logic [1:0] FLM_WIDTH_32 = 2'h2;

  // byte order codes
  localparam logic FLM_ORDER_LITTLE = 1'h0;
  localparam logic FLM_ORDER_BIG = 1'h1;

  // port selection codes for the three buffer ports
  localparam logic [1:0] FLM_PORT_CONTROL = 2'h0;
  localparam logic [1:0] FLM_PORT_DMA_ZERO = 2'h1;
  localparam logic [1:0] FLM_PORT_DMA_ONE = 2'h2;

  // buffer geometry and reset values
  localparam int FLM_SKID_DEPTH = 2;
  localparam logic [31:0] FLM_WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] FLM_COUNT_RESET = 2'h0;

  // bus-side access request
  typedef struct packed {
    logic [1:0] port;
    logic write;
    logic [1:0] port_access_width;
    logic byte_order_select;
    logic [31:0] wdata;
  } flm_req_type;

  // fifo-side byte group, byte n+0 in bits 7:0
  typedef struct packed {
    logic [1:0] port;
    logic [2:0] count;
    logic [31:0] bytes;
  } flm_fifo_type;

endpackage

// file: logic/flm_skid_buffer.sv
// two-entry buffer so a stall downstream loses nothing
module flm_skid_buffer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import flm_pkg::*;

  logic [WIDTH-1:0] mem_q [FLM_SKID_DEPTH];
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // honest flags from the occupancy count
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q <= FLM_COUNT_RESET;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // (R7) occupancy never passes two
  property p_no_overflow;
    @(posedge clk_sys) disable iff (!reset_n)
    count_q != 2'h3;
  endproperty
  a_no_overflow: assert property (p_no_overflow) // (R7)
    else $error("buffer occupancy beyond two");
  // (R6) word into empty buffer shows next
  property p_pop_needs_data;
    @(posedge clk_sys) disable iff (!reset_n)
    push && count_q == 2'h0 |=> out_valid && out_data == $past(in_data);
  endproperty
  a_pop_needs_data: assert property (p_pop_needs_data) // (R6)
    else $error("buffer lost a word into empty");
  // (R6) push with pop keeps order
  property p_order_kept;
    @(posedge clk_sys) disable iff (!reset_n)
    push && pop && count_q == 2'h1 |=> out_valid && out_data == $past(in_data);
  endproperty
  a_order_kept: assert property (p_order_kept) // (R6)
    else $error("buffer order broken");
endmodule

// file: logic/flm_lane_mapper.sv
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// (R1) 32-bit little puts n+0 on 7:0 up to n+3; big reverses it.
// (R2) 32-bit big order sends and stores bytes starting from n+3; the code starts from n+0 (bits 31:24) both ways.
// (R3) 16-bit little uses low half, big uses high half with n+0 upper.
// (R4) 16-bit big order sends and stores bytes starting from n+1; the code starts from n+0 (bits 31:24) both ways.
// (R5) 8-bit byte n+0 sits in lowest lane little, highest lane big.
// (R6) little order at 32 or 16 bits starts from n+0 both ways.
// (R7) prohibited lanes ignored on write, no pointer advance, read as zero.
module flm_lane_mapper (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // bus-side request
  input wire logic req_valid,
  output logic req_ready,
  input wire flm_pkg::flm_req_type req,
  // bus-side read answer
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  // fifo-side write stream (bytes leave in address order)
  output logic wr_valid,
  input wire logic wr_ready,
  output flm_pkg::flm_fifo_type wr_data,
  // fifo-side read: current bytes n+0.. of the selected port
  output logic rd_pop,
  output logic [1:0] rd_port,
  output logic [2:0] rd_count,
  input wire logic [31:0] rd_bytes
);
  import flm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // lane decode

  // byte count per width; an unknown width code moves nothing
  wire is_w32 = (req.port_access_width == FLM_WIDTH_32);
  wire is_w16 = (req.port_access_width == FLM_WIDTH_16);
  wire is_w8 = (req.port_access_width == FLM_WIDTH_8);
  wire big = (req.byte_order_select == FLM_ORDER_BIG);
  wire [2:0] nbytes = is_w32 ? 3'h4 : (is_w16 ? 3'h2 : (is_w8 ? 3'h1 : 3'h0));

  // (R1) 32-bit lane placement
  wire [31:0] map32 = big ? {req.wdata[7:0], req.wdata[15:8], req.wdata[23:16],
    req.wdata[31:24]} : req.wdata;
  // (R3) 16-bit half selection, byte n+0 lands in bits 7:0
  wire [31:0] map16 = big ? {16'h0000, req.wdata[23:16], req.wdata[31:24]} :
    {16'h0000, req.wdata[15:8], req.wdata[7:0]};
  // (R5) 8-bit single lane
  wire [31:0] map8 = big ? {24'h000000, req.wdata[31:24]} :
    {24'h000000, req.wdata[7:0]};

  // (R2) (R4) (R6) write bytes packed so n+0 leaves first
  // (R7) prohibited lanes are simply not sampled
  wire [31:0] fifo_bytes = is_w32 ? map32 : (is_w16 ? map16 : map8);

  // read lane placement mirrors the write side
  wire [31:0] r = rd_bytes;
  wire [31:0] rd32 = big ? {r[7:0], r[15:8], r[23:16], r[31:24]} : r;
  wire [31:0] rd16 = big ? {r[7:0], r[15:8], 16'h0000} : {16'h0000, r[15:8], r[7:0]};
  wire [31:0] rd8 = big ? {r[7:0], 24'h000000} : {24'h000000, r[7:0]};
  // (R7) prohibited lanes read as zero
  wire [31:0] rd_mapped = is_w32 ? rd32 : (is_w16 ? rd16 : (is_w8 ? rd8 :
    FLM_WORD_RESET));

  //////////////////////////////////////////////////////////////////////////
  // write path through the two-entry buffer

  logic buf_in_ready;
  logic buf_out_valid;
  flm_fifo_type buf_in;
  flm_fifo_type buf_out;
  assign buf_in = '{port: req.port, count: nbytes, bytes: fifo_bytes};

  // (R7) zero-byte writes never reach the fifo, so no pointer advance
  wire wr_take = req_valid && req.write && (nbytes != 3'h0);
  wire rd_take = req_valid && !req.write;
  wire wr_fill = wr_take && buf_in_ready;

  // reads answer from registers; writes wait for buffer room unless their width code moves no bytes
  assign req_ready = req.write ? (buf_in_ready || nbytes == 3'h0) : 1'b1;

  flm_skid_buffer #(
    .WIDTH($bits(flm_fifo_type))
  ) u_skid (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(wr_take),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(wr_ready),
    .out_data(buf_out)
  );

  assign wr_valid = buf_out_valid;
  assign wr_data = buf_out;

  //////////////////////////////////////////////////////////////////////////
  // read answer registers; outputs straight from flip-flops

  logic rsp_valid_q;
  logic [31:0] rsp_rdata_q;
  logic rd_pop_q;
  logic [1:0] rd_port_q;
  logic [2:0] rd_count_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= FLM_WORD_RESET;
      rd_pop_q <= 1'b0;
      rd_port_q <= FLM_PORT_CONTROL;
      rd_count_q <= 3'h0;
    end else begin
      rsp_valid_q <= rd_take;
      rsp_rdata_q <= rd_take ? rd_mapped : FLM_WORD_RESET;
      rd_pop_q <= rd_take && (nbytes != 3'h0);
      rd_port_q <= req.port;
      rd_count_q <= rd_take ? nbytes : 3'h0;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rd_pop = rd_pop_q;
  assign rd_port = rd_port_q;
  assign rd_count = rd_count_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  // (R1) big 32-bit read flips all lanes
  property p_r1_big32;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take && is_w32 && big |=> rsp_rdata == {$past(rd_bytes[7:0]), $past(rd_bytes[15:8]),
      $past(rd_bytes[23:16]), $past(rd_bytes[31:24])};
  endproperty
  a_r1_big32: assert property (p_r1_big32) // (R1)
    else $error("32-bit big read lane wrong");
  // (R1) little 32-bit read passes lanes
  property p_r1_little32;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take && is_w32 && !big |=> rsp_rdata == $past(rd_bytes);
  endproperty
  a_r1_little32: assert property (p_r1_little32) // (R1)
    else $error("32-bit little read lane wrong");
  // (R2) big 32-bit write sends top lane first
  property p_r2_first;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_fill && is_w32 && big && !buf_out_valid |=>
      wr_data.bytes[7:0] == $past(req.wdata[31:24]);
  endproperty
  a_r2_first: assert property (p_r2_first) // (R2)
    else $error("32-bit big write order wrong");
  // (R3) 16-bit little read keeps upper half zero
  property p_r3_half;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take && is_w16 && !big |=> rsp_rdata[31:16] == 16'h0000;
  endproperty
  a_r3_half: assert property (p_r3_half) // (R3)
    else $error("16-bit prohibited half not zero");
  // (R3) 16-bit big read keeps lower half zero
  property p_r3_big16;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take && is_w16 && big |=> rsp_rdata[15:0] == 16'h0000 &&
      rsp_rdata[31:24] == $past(rd_bytes[7:0]);
  endproperty
  a_r3_big16: assert property (p_r3_big16) // (R3)
    else $error("16-bit big read half wrong");
  // (R4) 16-bit big write sends bits 31:24 first
  property p_r4_first;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_fill && is_w16 && big && !buf_out_valid |=>
      wr_data.bytes[7:0] == $past(req.wdata[31:24]) && wr_data.count == 3'h2;
  endproperty
  a_r4_first: assert property (p_r4_first) // (R4)
    else $error("16-bit big write order wrong");
  // (R5) 8-bit big read lands in the top lane only
  property p_r5_byte;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take && is_w8 && big |=> rsp_rdata == {$past(rd_bytes[7:0]), 24'h000000};
  endproperty
  a_r5_byte: assert property (p_r5_byte) // (R5)
    else $error("8-bit big read lane wrong");
  // (R5) 8-bit little read lands in the low lane only
  property p_r5_little8;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take && is_w8 && !big |=> rsp_rdata == {24'h000000, $past(rd_bytes[7:0])};
  endproperty
  a_r5_little8: assert property (p_r5_little8) // (R5)
    else $error("8-bit little read lane wrong");
  // (R6) little write sends bits 7:0 first
  property p_r6_first;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_fill && !big && !is_w8 && nbytes != 3'h0 && !buf_out_valid |=>
      wr_data.bytes[7:0] == $past(req.wdata[7:0]);
  endproperty
  a_r6_first: assert property (p_r6_first) // (R6)
    else $error("little write order wrong");
  // (R6) taken read answers next cycle
  property p_rsp_pulse;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_take |=> rsp_valid && rd_count == $past(nbytes);
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) // (R6)
    else $error("read answer missing");
  // (R6) stalled byte group holds still
  property p_wr_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) // (R6)
    else $error("stalled write group changed");
  // (R7) an unknown width never moves fifo data
  property p_r7_none;
    @(posedge clk_sys) disable iff (!reset_n)
    req_valid && nbytes == 3'h0 |=> !rd_pop && rsp_rdata == 32'h0000_0000;
  endproperty
  a_r7_none: assert property (p_r7_none) // (R7)
    else $error("prohibited access moved data");
  // (R7) dropped write leaves buffer empty
  property p_r7_drop;
    @(posedge clk_sys) disable iff (!reset_n)
    req_valid && req.write && nbytes == 3'h0 && !wr_valid |=> !wr_valid;
  endproperty
  a_r7_drop: assert property (p_r7_drop) // (R7)
    else $error("prohibited write reached the buffer");
  // (R7) idle cycles answer nothing
  property p_rsp_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    !rd_take |=> !rsp_valid && !rd_pop && rsp_rdata == 32'h0000_0000;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle) // (R7)
    else $error("answer without a read");
  // (R7) pop only with bytes
  property p_pop_count;
    @(posedge clk_sys) disable iff (!reset_n)
    rd_pop |-> rd_count != 3'h0 && rsp_valid;
  endproperty
  a_pop_count: assert property (p_pop_count) // (R7)
    else $error("pop without bytes");
endmodule

// file: testbench/flm_fifo_model.sv
// endpoint buffer stand-in: serves bytes n+0.. and sinks byte groups
module flm_fifo_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // read side
  input wire logic [1:0] port,
  output logic [31:0] rd_bytes,
  // write stream
  input wire logic stall,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire flm_pkg::flm_fifo_type wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import flm_pkg::*;
  flm_fifo_type got[$];
  // bytes differ per port so a wrong port selection shows up
  assign rd_bytes = 32'hD3C2B1A0 ^ {4{6'h00, port}};
  // stalls only when the bench asks, to exercise the buffer
  assign wr_ready = ~stall;
  // accepted groups kept in arrival order
  always @(posedge clk_sys) begin
    if (reset_n && wr_valid && wr_ready) begin
      got.push_back(wr_data);
    end
  end
endmodule

// file: testbench/flm_lane_mapper_tb.sv
module flm_lane_mapper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flm_pkg::*;
  logic clk_sys, reset_n, req_valid, req_ready, rsp_valid, wr_valid, wr_ready, rd_pop, stall;
  flm_req_type req;
  flm_fifo_type wr_data;
  logic [31:0] rsp_rdata, rd_bytes;
  logic [1:0] rd_port;
  logic [2:0] rd_count;
  int errors, compares;
  flm_lane_mapper flm_lane_mapper_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_pop(rd_pop), .rd_port(rd_port), .rd_count(rd_count), .rd_bytes(rd_bytes));
  flm_fifo_model flm_fifo_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .port(req.port),
    .rd_bytes(rd_bytes), .stall(stall), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data));
  //////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] sw(input logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  // expected port image of fifo bytes b for a read
  function automatic logic [31:0] rd_exp(input int w, input int o, input logic [31:0] b);
    case (w)
      2: return o ? sw(b) : b;
      1: return o ? {b[7:0], b[15:8], 16'h0000} : {16'h0000, b[15:0]};
      0: return o ? {b[7:0], 24'h000000} : {24'h000000, b[7:0]};
      default: return 32'h0000_0000;
    endcase
  endfunction
  // expected fifo bytes, n+0 lowest, for a write of d
  function automatic logic [31:0] wr_exp(input int w, input int o, input logic [31:0] d);
    case (w)
      2: return o ? sw(d) : d;
      1: return o ? {16'h0000, d[23:16], d[31:24]} : {16'h0000, d[15:0]};
      default: return o ? {24'h000000, d[31:24]} : {24'h000000, d[7:0]};
    endcase
  endfunction
  // request held until taken; valid stays up so requests run back to back
  task automatic req_op(input flm_req_type r);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = r;
    #1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    check(req_ready, 1);
    @(negedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // back-to-back reads over every port, width code and order
  task automatic t_reads;
    logic [31:0] b;
    for (int i = 0; i < 24; i++) begin
      req_op('{2'(i % 3), 1'b0, 2'(i / 6), 1'(i / 3), 32'h0});
      b = 32'hD3C2B1A0 ^ {4{6'h00, 2'(i % 3)}};
      check(rsp_rdata, rd_exp(i / 6, (i / 3) % 2, b));
      check(rsp_valid, 1);
      check(rd_pop, (i / 6) != 3);
      check(rd_port, i % 3);
      check(rd_count, (i / 6) == 3 ? 0 : ((i / 6) == 2 ? 4 : (i / 6) + 1));
    end
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  // writes of every width and order, then one with the prohibited width code
  task automatic t_writes;
    flm_fifo_type g;
    logic [31:0] m;
    int w;
    for (int i = 0; i < 6; i++) req_op('{2'(i % 3), 1'b1, 2'(i / 2), 1'(i % 2), 32'hA1B2C3D4 + i});
    req_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    // unused width code into an empty buffer: nothing may show up
    req_op('{2'h0, 1'b1, 2'h3, 1'b0, 32'hFFFFFFFF});
    req_valid = 1'b0;
    check(wr_valid, 0);
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      w = i / 2;
      m = w == 2 ? 32'hFFFFFFFF : (w == 1 ? 32'h0000FFFF : 32'h000000FF);
      g = flm_fifo_model_i.got.size() ? flm_fifo_model_i.got.pop_front() : '0;
      check(g.bytes & m, wr_exp(w, i % 2, 32'hA1B2C3D4 + i));
      check(g.count, w == 2 ? 4 : w + 1);
      check(g.port, i % 3);
    end
    check(flm_fifo_model_i.got.size(), 0);
  endtask
  // receiver stalls: third write refused, nothing lost, order kept
  task automatic t_stall;
    flm_fifo_type g;
    stall = 1'b1;
    for (int i = 0; i < 2; i++) begin
      req_op('{2'h1, 1'b1, FLM_WIDTH_32, FLM_ORDER_BIG, 32'h11223340 + i});
    end
    req = '{2'h2, 1'b1, FLM_WIDTH_32, FLM_ORDER_BIG, 32'h11223342};
    #1;
    check(req_ready, 0);
    check(wr_valid, 1);
    @(negedge clk_sys);
    stall = 1'b0;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      g = flm_fifo_model_i.got.size() ? flm_fifo_model_i.got.pop_front() : '0;
      check(g.bytes, sw(32'h11223340 + i));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    stall = 1'b0;
    errors = 0;
    compares = 0;
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    check(req_ready, 1);
    check(wr_valid, 0);
    t_reads;
    t_writes;
    t_stall;
    final_report;
  end
  // watchdog, far beyond the fifty-odd cycles the tests need
  initial begin
    #20000;
    errors++;
    final_report;
  end
endmodule
